// ===== hdl/eep_top.sv
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "eep_map.svh"
module eep_top #(
   parameter logic [3:0]  DEV_CODE = 4'h6, // arbitrary value
   parameter int unsigned PROG_CYC = `EEP_PROG_CYC
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // serial lines
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // straps
   input  wire logic        wp_i,
   input  wire logic        slave_addr_bit_high,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);
   localparam int unsigned AW = `EEP_ADDR_W;
   localparam int unsigned PA = `EEP_PAGE_AW;
   localparam int unsigned PW = $clog2(PROG_CYC + 1);

   eep_pkg::eep_state_t state_reg;
   eep_pkg::eep_state_t state_next;
   logic [3:0]    bit_reg;
   logic [3:0]    bit_next;
   logic [7:0]    shift_reg;
   logic [7:0]    shift_next;
   logic          oe_reg;
   logic          oe_next;
   logic          mack_reg;
   logic          mack_next;
   logic [AW-1:0] addr_reg;
   logic [AW-1:0] addr_next;
   logic [4:0]    ahi_reg;
   logic [4:0]    ahi_next;
   logic [AW-1:0] saddr_reg;
   logic [AW-1:0] saddr_next;
   logic [5:0]    wcnt_reg;
   logic [5:0]    wcnt_next;
   logic [31:0]   mask_reg;
   logic [31:0]   mask_next;
   logic          wps_reg;
   logic          wps_next;
   logic          busy_reg;
   logic          busy_next;
   logic [PW-1:0] prog_reg;
   logic [PW-1:0] prog_next;
   logic          buf_we;
   logic          wp_s1_reg;
   logic          wp_sync;
   logic          sel_s1_reg;
   logic          sel_sync;
   logic          wait_reg;
   logic          wait_next;
   logic [31:0]   rdata_reg;
   logic [31:0]   rdata_next;
   logic [AW-1:0] maddr_reg;
   logic [AW-1:0] maddr_next;
   logic          bus_mwr;
   logic          commit;
   logic          dev_match;
   logic          scl_f;
   logic          sda_f;
   logic [7:0]    rd_byte;
   logic [7:0]    mem [0:`EEP_ARRAY_SZ-1];
   logic [7:0]    page_buf [0:`EEP_PAGE_BYTES-1];

   eep_bus_if ev ();

   ////////////////////////////////////////////////////////////////////////
   eep_filt u_scl_filt (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_i   (scl_i),
      .level_o (scl_f)
   );
   eep_filt u_sda_filt (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_i   (sda_i),
      .level_o (sda_f)
   );
   eep_cond u_cond (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .scl_i   (scl_f),
      .sda_i   (sda_f),
      .ev      (ev.det)
   );

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_s1_reg  <= 1'b0;
         wp_sync    <= 1'b0;
         sel_s1_reg <= 1'b0;
         sel_sync   <= 1'b0;
      end else begin
         wp_s1_reg  <= wp_i;
         wp_sync    <= wp_s1_reg;
         sel_s1_reg <= slave_addr_bit_high;
         sel_sync   <= sel_s1_reg;
      end
   end

   // writes stay inside the page, reads run over the whole array
   function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a,
                                               input logic in_page);
      if (in_page) next_addr = {a[AW-1:PA], a[PA-1:0] + 1'b1};
      else next_addr = a + 1'b1;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register bus: one wait cycle, then a one-cycle answer
   assign bus_mwr = avs_write & ~wait_reg & avs_byteenable[0]
                    & (avs_address == `EEP_REG_MDATA);

   always_comb begin
      wait_next  = ~((avs_read | avs_write) & wait_reg);
      rdata_next = 32'h0000_0000;
      maddr_next = maddr_reg;
      if (avs_read & wait_reg) begin
         unique case (avs_address)
            `EEP_REG_STATUS: begin
               rdata_next[AW-1:0]        = addr_reg;
               rdata_next[`EEP_ST_BUSY] = busy_reg;
               rdata_next[`EEP_ST_WP]   = wp_sync;
            end
            `EEP_REG_MADDR: rdata_next[AW-1:0] = maddr_reg;
            `EEP_REG_MDATA: rdata_next[7:0] = mem[maddr_reg];
            default: rdata_next = 32'h0000_0000;
         endcase
      end
      if (avs_write & ~wait_reg & (avs_address == `EEP_REG_MADDR)) begin
         if (avs_byteenable[0]) maddr_next[7:0] = avs_writedata[7:0];
         if (avs_byteenable[1]) maddr_next[AW-1:8] = avs_writedata[AW-1:8];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
         maddr_reg <= `EEP_ADDR_RST;
      end else begin
         wait_reg  <= wait_next;
         rdata_reg <= rdata_next;
         maddr_reg <= maddr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial protocol engine
   assign rd_byte   = mem[addr_reg];
   assign dev_match = (shift_reg[7:4] == DEV_CODE)
                      & (shift_reg[3:1] == {sel_sync, `EEP_SLV_MID, `EEP_SLV_LOW});
   assign commit    = busy_reg & (prog_reg < PW'(`EEP_PAGE_BYTES)) & ~bus_mwr;

   always_comb begin
      state_next = state_reg;
      bit_next   = bit_reg;
      shift_next = shift_reg;
      oe_next    = oe_reg;
      mack_next  = mack_reg;
      addr_next  = addr_reg;
      ahi_next   = ahi_reg;
      saddr_next = saddr_reg;
      wcnt_next  = wcnt_reg;
      mask_next  = mask_reg;
      wps_next   = wps_reg | wp_sync;
      busy_next  = busy_reg;
      prog_next  = prog_reg;
      buf_we     = 1'b0;
      if (busy_reg) begin
         // deaf while programming: no ack, no reset
         oe_next    = 1'b0;
         state_next = eep_pkg::st_idle;
         if (!bus_mwr) begin
            prog_next = prog_reg + 1'b1;
            if (prog_reg == PW'(PROG_CYC - 1)) begin
               busy_next = 1'b0;
               prog_next = '0;
               mask_next = 32'h0000_0000;
            end
         end
      end else if (ev.start) begin
         // any start aborts a partial command
         state_next = eep_pkg::st_dev;
         bit_next   = 4'h0;
         oe_next    = 1'b0;
         wps_next   = wp_sync;
         wcnt_next  = 6'h00;
         mask_next  = 32'h0000_0000;
      end else if (ev.stop) begin
         state_next = eep_pkg::st_idle;
         oe_next    = 1'b0;
         if (state_reg == eep_pkg::st_wdat && wcnt_reg != 6'h00) begin
            busy_next = ~wps_reg;
            if (wcnt_reg > 6'(`EEP_PAGE_BYTES)) addr_next = saddr_reg;
         end
      end else if (ev.scl_rise) begin
         if (bit_reg < 4'h9) bit_next = bit_reg + 1'b1;
         if (state_reg == eep_pkg::st_rd) begin
            if (bit_reg == 4'h8) mack_next = ~ev.sda;
         end else if (bit_reg < 4'h8) begin
            shift_next = {shift_reg[6:0], ev.sda};
         end
      end else if (ev.scl_fall) begin
         unique case (state_reg)
            eep_pkg::st_dev: begin
               if (bit_reg == 4'h8) begin
                  oe_next = dev_match;
                  if (!dev_match) state_next = eep_pkg::st_wait;
               end else if (bit_reg == 4'h9) begin
                  bit_next = 4'h0;
                  if (shift_reg[0]) begin
                     // read needs no protect check
                     state_next = eep_pkg::st_rd;
                     shift_next = rd_byte;
                     oe_next    = ~rd_byte[7];
                     addr_next  = next_addr(addr_reg, 1'b0);
                  end else begin
                     state_next = eep_pkg::st_ahi;
                     oe_next    = 1'b0;
                  end
               end
            end
            eep_pkg::st_ahi: begin
               if (bit_reg == 4'h8) oe_next = 1'b1;
               else if (bit_reg == 4'h9) begin
                  ahi_next   = shift_reg[4:0];
                  oe_next    = 1'b0;
                  bit_next   = 4'h0;
                  state_next = eep_pkg::st_alo;
               end
            end
            eep_pkg::st_alo: begin
               if (bit_reg == 4'h8) begin
                  oe_next    = 1'b1;
                  addr_next  = {ahi_reg, shift_reg};
                  saddr_next = {ahi_reg, shift_reg};
               end else if (bit_reg == 4'h9) begin
                  oe_next    = 1'b0;
                  bit_next   = 4'h0;
                  state_next = eep_pkg::st_wdat;
               end
            end
            eep_pkg::st_wdat: begin
               if (bit_reg == 4'h8) begin
                  oe_next   = 1'b1;
                  buf_we    = 1'b1;
                  mask_next = mask_reg | (32'h0000_0001 << addr_reg[PA-1:0]);
                  addr_next = next_addr(addr_reg, 1'b1);
                  if (wcnt_reg != 6'h3F) wcnt_next = wcnt_reg + 1'b1;
               end else if (bit_reg == 4'h9) begin
                  oe_next  = 1'b0;
                  bit_next = 4'h0;
               end
            end
            eep_pkg::st_rd: begin
               if (bit_reg >= 4'h1 && bit_reg <= 4'h7) begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  oe_next    = ~shift_reg[6];
               end else if (bit_reg == 4'h8) begin
                  oe_next = 1'b0;
               end else if (bit_reg == 4'h9) begin
                  bit_next = 4'h0;
                  if (mack_reg) begin
                     shift_next = rd_byte;
                     oe_next    = ~rd_byte[7];
                     addr_next  = next_addr(addr_reg, 1'b0);
                  end else begin
                     state_next = eep_pkg::st_wait;
                     oe_next    = 1'b0;
                  end
               end
            end
            eep_pkg::st_idle, eep_pkg::st_wait: oe_next = 1'b0;
            default: state_next = eep_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= eep_pkg::st_idle;
         bit_reg   <= 4'h0;
         shift_reg <= 8'h00;
         oe_reg    <= 1'b0;
         mack_reg  <= 1'b0;
         addr_reg  <= `EEP_ADDR_RST;
         ahi_reg   <= 5'h00;
         saddr_reg <= `EEP_ADDR_RST;
         wcnt_reg  <= 6'h00;
         mask_reg  <= 32'h0000_0000;
         wps_reg   <= 1'b0;
         busy_reg  <= 1'b0;
         prog_reg  <= '0;
      end else begin
         state_reg <= state_next;
         bit_reg   <= bit_next;
         shift_reg <= shift_next;
         oe_reg    <= oe_next;
         mack_reg  <= mack_next;
         addr_reg  <= addr_next;
         ahi_reg   <= ahi_next;
         saddr_reg <= saddr_next;
         wcnt_reg  <= wcnt_next;
         mask_reg  <= mask_next;
         wps_reg   <= wps_next;
         busy_reg  <= busy_next;
         prog_reg  <= prog_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // page latches; a serial write reaches the array only once the stop is seen
   always_ff @(posedge ref_clk) begin
      if (buf_we) page_buf[addr_reg[PA-1:0]] <= shift_reg;
   end

   // one byte per cycle; a bus write stalls the walk instead of colliding
   always_ff @(posedge ref_clk) begin
      if (commit && mask_reg[prog_reg[PA-1:0]]) begin
         mem[{saddr_reg[AW-1:PA], prog_reg[PA-1:0]}] <= page_buf[prog_reg[PA-1:0]];
      end else if (bus_mwr) begin
         mem[maddr_reg] <= avs_writedata[7:0];
      end
   end

   assign sda_o           = 1'b0;
   assign sda_oe          = oe_reg;
   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_fall(eep_pkg::eep_state_t st, logic [3:0] b);
      !busy_reg && !ev.start && !ev.stop && ev.scl_fall
      && state_reg == st && bit_reg == b;
   endsequence
   sequence s_wr_stop;
      !busy_reg && ev.stop && state_reg == eep_pkg::st_wdat && wcnt_reg != 6'h00;
   endsequence

   property p_poll_nack;
      busy_reg && ev.scl_fall |=> !oe_reg;
   endproperty
   a_poll_nack: assert property (p_poll_nack) else $error("ack during programming");
   property p_ready_ack;
      s_fall(eep_pkg::st_dev, 4'h8) ##0 dev_match |=> oe_reg;
   endproperty
   a_ready_ack: assert property (p_ready_ack) else $error("address not acked");
   property p_addr_match;
      s_fall(eep_pkg::st_dev, 4'h8) ##0 !dev_match |=> !oe_reg && state_reg == eep_pkg::st_wait;
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("foreign address acked");
   property p_rd_first;
      s_fall(eep_pkg::st_dev, 4'h9) ##0 shift_reg[0] |=> state_reg == eep_pkg::st_rd
         && shift_reg == $past(rd_byte) && addr_reg == $past(addr_reg) + 1'b1;
   endproperty
   a_rd_first: assert property (p_rd_first) else $error("bad first read byte");
   property p_seq_inc;
      s_fall(eep_pkg::st_rd, 4'h9) ##0 mack_reg |=> addr_reg == $past(addr_reg) + 1'b1
         && oe_reg == !$past(rd_byte[7]);
   endproperty
   a_seq_inc: assert property (p_seq_inc) else $error("read did not advance");
   property p_page_wrap;
      s_fall(eep_pkg::st_wdat, 4'h8) |=> addr_reg[AW-1:PA] == $past(addr_reg[AW-1:PA]);
   endproperty
   a_page_wrap: assert property (p_page_wrap) else $error("write left its page");
   property p_prog_start;
      s_wr_stop ##0 !wps_reg |=> busy_reg [*8];
   endproperty
   a_prog_start: assert property (p_prog_start) else $error("no programming on stop");
   property p_wp_block;
      s_wr_stop ##0 wps_reg |=> !busy_reg;
   endproperty
   a_wp_block: assert property (p_wp_block) else $error("protected write programmed");
   property p_overflow;
      s_wr_stop ##0 wcnt_reg > 6'h20 |=> addr_reg == $past(saddr_reg);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow address wrong");
   property p_sw_reset;
      !busy_reg && ev.start |=> state_reg == eep_pkg::st_dev && bit_reg == 4'h0 && !oe_reg;
   endproperty
   a_sw_reset: assert property (p_sw_reset) else $error("start did not reset");
   property p_busy_deaf;
      busy_reg && ev.start |=> state_reg == eep_pkg::st_idle;
   endproperty
   a_busy_deaf: assert property (p_busy_deaf) else $error("reset acted while busy");
   property p_stop_idle;
      !busy_reg && ev.stop |=> state_reg == eep_pkg::st_idle && !oe_reg;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop left engine active");
endmodule // eep_top
`default_nettype wire

// ===== hdl/eep_map.svh
`ifndef EEP_MAP_SVH
`define EEP_MAP_SVH
`define EEP_CLK_NS     40
`define EEP_FILT_NS    100
`define EEP_FILT_CYC   ((`EEP_FILT_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`define EEP_PROG_NS    5000000
`define EEP_PROG_CYC   (`EEP_PROG_NS / `EEP_CLK_NS)
`define EEP_ADDR_W     13
`define EEP_ARRAY_SZ   8192
`define EEP_PAGE_AW    5
`define EEP_PAGE_BYTES 32
`define EEP_ADDR_RST   13'h0000
`define EEP_SLV_MID    1'b0
`define EEP_SLV_LOW    1'b0
`define EEP_REG_STATUS 4'h0
`define EEP_REG_MADDR  4'h4
`define EEP_REG_MDATA  4'h8
`define EEP_ST_BUSY    16
`define EEP_ST_WP      17
`endif

// ===== hdl/eep_pkg.sv
package eep_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_dev  = 3'b001,
      st_ahi  = 3'b010,
      st_alo  = 3'b011,
      st_wdat = 3'b100,
      st_rd   = 3'b101,
      st_wait = 3'b110
   } eep_state_t;
endpackage

// ===== hdl/eep_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface eep_bus_if;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport det  (output sda, scl_rise, scl_fall, start, stop);
   modport core (input  sda, scl_rise, scl_fall, start, stop);
endinterface // eep_bus_if
`default_nettype wire

// ===== hdl/eep_filt.sv
`timescale 1ns/10ps
`default_nettype none
`include "eep_map.svh"
module eep_filt #(
   parameter int unsigned FILT_CYC = `EEP_FILT_CYC
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // raw pin in, clean level out
   input  wire logic pin_i,
   output logic      level_o
);
   localparam int unsigned CW = $clog2(FILT_CYC + 1);
   logic          sync1_reg;
   logic          sync2_reg;
   logic          level_reg;
   logic          level_next;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= pin_i;
         sync2_reg <= sync1_reg;
      end
   end

   // a level must differ for FILT_CYC+1 samples to pass
   always_comb begin
      level_next = level_reg;
      cnt_next   = '0;
      if (sync2_reg != level_reg) begin
         if (cnt_reg == CW'(FILT_CYC)) level_next = sync2_reg;
         else cnt_next = cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         level_reg <= 1'b1;
         cnt_reg   <= '0;
      end else begin
         level_reg <= level_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign level_o = level_reg;
endmodule // eep_filt
`default_nettype wire

// ===== hdl/eep_cond.sv
`timescale 1ns/10ps
`default_nettype none
module eep_cond (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // clean line levels
   input  wire logic scl_i,
   input  wire logic sda_i,
   // events to the core
   eep_bus_if.det    ev
);
   logic       scl_reg;
   logic       sda_reg;
   logic [3:0] ev_reg;
   logic [3:0] ev_next;

   // start and stop need the clock high in both samples
   always_comb begin
      ev_next[0] = scl_i & ~scl_reg;
      ev_next[1] = ~scl_i & scl_reg;
      ev_next[2] = scl_i & scl_reg & sda_reg & ~sda_i;
      ev_next[3] = scl_i & scl_reg & ~sda_reg & sda_i;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         ev_reg  <= 4'h0;
      end else begin
         scl_reg <= scl_i;
         sda_reg <= sda_i;
         ev_reg  <= ev_next;
      end
   end

   assign ev.sda      = sda_reg;
   assign ev.scl_rise = ev_reg[0];
   assign ev.scl_fall = ev_reg[1];
   assign ev.start    = ev_reg[2];
   assign ev.stop     = ev_reg[3];
endmodule // eep_cond
`default_nettype wire

// ===== verif/eep_i2c_mst.sv
`timescale 1ns/10ps
`default_nettype none
module eep_i2c_mst (
   // clock
   input  wire logic ref_clk,
   // data wire level
   input  wire logic sda_in,
   // master lines
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // a one is sent by releasing the line to its pull-up, never driven high
   task automatic bt(input logic b, output logic r);
      sda_low <= ~b;
      wt(4);
      scl <= 1'b1;
      wt(13);
      r = sda_in;
      scl <= 1'b0;
      wt(9);
   endtask
   task automatic start();
      sda_low <= 1'b0;
      wt(4);
      scl <= 1'b1;
      wt(13);
      sda_low <= 1'b1;
      wt(13);
      scl <= 1'b0;
      wt(9);
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      wt(4);
      scl <= 1'b1;
      wt(13);
      sda_low <= 1'b0;
      wt(13);
   endtask
   // type code, strap bit, two zero bits, direction, msb first
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bt(d[i], r);
      bt(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bt(1'b1, r);
         d[i] = r;
      end
      bt(~mack, r);
   endtask
   task automatic swreset();
      logic r;
      start();
      repeat (9) bt(1'b1, r);
      start();
      stop();
   endtask
endmodule // eep_i2c_mst
`default_nettype wire

// ===== verif/serial_eeprom_read_poll_protect_test.sv
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_read_poll_protect_test;
   // short programming time keeps the run brief; still outlasts one poll word
   localparam int unsigned PROG = 600;
   logic        ref_clk, rst_n, wp_i, scl, sda_low, sda_o, sda_oe, sda, ack;
   logic        avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [7:0]  d;
   logic [12:0] pa [4] = '{13'h1FFE, 13'h1FFF, 13'h0000, 13'h0001};
   logic [7:0]  pd [4] = '{8'h5A, 8'hA5, 8'h3C, 8'h11};
   int          bad_count, samples_checked, n;
   // open drain with pull-up
   assign sda = ((sda_oe & ~sda_o) | sda_low) ? 1'b0 : 1'b1;
   eep_top #(.DEV_CODE(4'h6), .PROG_CYC(PROG)) i_eep_top (
      .ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .wp_i(wp_i), .slave_addr_bit_high(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   eep_i2c_mst i_eep_i2c_mst (.ref_clk(ref_clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= w;
      avs_read      <= ~w;
      // no local limit: a slave that never answers is caught by the watchdog
      do @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic cmd(input logic [7:0] b, input logic exp);
      i_eep_i2c_mst.wbyte(b, ack);
      chk(32'(ack), 32'(exp));
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #2ms;
      bad_count++;
      complete_run();
   end
   initial begin
      {rst_n, wp_i, avs_read, avs_write, avs_address, avs_writedata} = '0;
      bad_count = 0;
      samples_checked = 0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      i_eep_i2c_mst.swreset();
      rdc(4'h0, 32'h0);
      rdc(4'hC, 32'h0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 4'h4, {19'h0, pa[i]});
         bus(1'b1, 4'h8, {24'h0, pd[i]});
      end
      // random read; high address bits above the counter width must drop
      i_eep_i2c_mst.start();
      cmd(8'h68, 1'b1);
      cmd(8'hFF, 1'b1);
      cmd(8'hFE, 1'b1);
      i_eep_i2c_mst.start();
      cmd(8'h69, 1'b1);
      for (int i = 0; i < 3; i++) begin
         i_eep_i2c_mst.rbyte(i < 2, d);
         chk(32'(d), 32'(pd[i]));
      end
      i_eep_i2c_mst.stop();
      rdc(4'h0, 32'h1);
      i_eep_i2c_mst.start();
      cmd(8'h60, 1'b0);
      i_eep_i2c_mst.stop();
      wp_i <= 1'b1;
      i_eep_i2c_mst.start();
      cmd(8'h69, 1'b1);
      i_eep_i2c_mst.rbyte(1'b0, d);
      chk(32'(d), 32'h11);
      i_eep_i2c_mst.stop();
      i_eep_i2c_mst.start();
      cmd(8'h68, 1'b1);
      cmd(8'h00, 1'b1);
      cmd(8'h01, 1'b1);
      cmd(8'h77, 1'b1);
      i_eep_i2c_mst.stop();
      rdc(4'h0, 32'h0002_0002);
      bus(1'b1, 4'h4, 32'h1);
      rdc(4'h8, 32'h11);
      wp_i <= 1'b0;
      // page write crossing the page end
      i_eep_i2c_mst.start();
      cmd(8'h68, 1'b1);
      cmd(8'h00, 1'b1);
      cmd(8'h1F, 1'b1);
      cmd(8'h81, 1'b1);
      cmd(8'h82, 1'b1);
      i_eep_i2c_mst.stop();
      rdc(4'h0, 32'h0001_0001);
      i_eep_i2c_mst.start();
      cmd(8'h68, 1'b0);
      i_eep_i2c_mst.stop();
      n = 0;
      ack = 1'b0;
      while (!ack && n < 4) begin
         i_eep_i2c_mst.start();
         i_eep_i2c_mst.wbyte(8'h68, ack);
         i_eep_i2c_mst.stop();
         n++;
      end
      chk(32'(ack), 32'h1);
      rdc(4'h0, 32'h0001);
      bus(1'b1, 4'h4, 32'h1F);
      rdc(4'h8, 32'h81);
      bus(1'b1, 4'h4, 32'h0);
      rdc(4'h8, 32'h82);
      // more than a page of data: counter falls back to the command address
      i_eep_i2c_mst.start();
      cmd(8'h68, 1'b1);
      cmd(8'h00, 1'b1);
      cmd(8'h40, 1'b1);
      for (int i = 0; i < 33; i++) begin
         cmd(8'(i), 1'b1);
      end
      i_eep_i2c_mst.stop();
      rdc(4'h0, 32'h0001_0040);
      complete_run();
   end
endmodule // serial_eeprom_read_poll_protect_test
`default_nettype wire
